//--- cbi_bus_if.sv
// cpu-side asynchronous bus master: strobes, arbitration, interrupt level
`timescale 1ns/1ps
`include "cbi_regs.svh"
module cbi_bus_if
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire cbi_pkg::cbi_req_t core_req,
    output logic core_ready,
    output cbi_pkg::cbi_rsp_t core_rsp,
    input wire logic [2:0] irq_mask,
    output logic [2:0] irq_pending,
    input wire logic width_sel_16,
    input wire logic halt_n,
    input wire logic xfer_ack_n,
    input wire logic bus_fault_n,
    input wire logic auto_vector_req_n,
    input wire logic mastership_request_n,
    output logic mastership_grant_n,
    input wire logic irq_level_bit2_n,
    input wire logic irq_level_bit1_n,
    input wire logic irq_level_bit0_n,
    output logic [23:0] addr_out,
    output logic addr_oe_n,
    output logic [15:0] data_out,
    input wire logic [15:0] data_in,
    output logic data_oe_n,
    output logic addr_strobe_n,
    output logic upper_byte_strobe_n,
    output logic lower_byte_strobe_n,
    output logic read_write,
    output logic space_code_bit2,
    output logic space_code_bit1,
    output logic space_code_bit0
);
    import cbi_pkg::*;

    cbi_regs_t r;
    cbi_regs_t next_r;
    logic [2:0] lvl;
    logic ended;

    // ========================================
    // interrupt level decode
    // three inputs, active low
    assign lvl = ~{irq_level_bit2_n, irq_level_bit1_n, irq_level_bit0_n};
    assign ended = !xfer_ack_n || !bus_fault_n || (r.wait_cnt == `CBI_ACK_TIMEOUT);

    // iack address: level on bits 3..1, all else high
    function automatic logic [23:0] iack_addr(input logic [2:0] l);
        iack_addr = {20'hfffff, l, 1'b1};
    endfunction

    // ========================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.rsp.done = 1'b0;
        next_r.ipl = (lvl == 3'h7 || lvl > irq_mask) ? lvl : 3'h0;
        case (r.st)
            CBI_IDLE:
            begin
                if (!halt_n)
                    next_r.st = CBI_HALT;
                else if (!mastership_request_n)
                begin
                    next_r.st = CBI_GRANT;
                    next_r.grant_n = 1'b0;
                    next_r.bus_oe_n = 1'b1;
                end
                else if (core_req.valid)
                begin
                    next_r.cur = core_req;
                    if (core_req.iack)
                    begin
                        next_r.cur.addr = iack_addr(core_req.addr[3:1]);
                        next_r.cur.fc = `CBI_FC_IACK;
                    end
                    next_r.bus_oe_n = 1'b0;
                    next_r.busy = 1'b1;
                    next_r.wait_cnt = 8'h00;
                    next_r.st = CBI_ADDR;
                end
            end
            CBI_ADDR:
            begin
                next_r.as_n = 1'b0;
                next_r.data_oe_n = r.cur.read;
                next_r.uds_n = width_sel_16 ? r.cur.size_sel[1] : r.cur.addr[0];
                next_r.lds_n = width_sel_16 ? r.cur.size_sel[0] : 1'b0;
                next_r.st = CBI_STRB;
            end
            CBI_STRB:
            begin
                next_r.wait_cnt = r.wait_cnt + 8'h01;
                if (ended)
                begin
                    next_r.as_n = 1'b1;
                    next_r.uds_n = 1'b1;
                    next_r.lds_n = 1'b1;
                    next_r.data_oe_n = 1'b1;
                    next_r.rsp.done = 1'b1;
                    next_r.rsp.fault = !bus_fault_n || xfer_ack_n;
                    next_r.rsp.autovec = r.cur.iack && !auto_vector_req_n;
                    next_r.rsp.rdata = data_in;
                    next_r.st = CBI_DONE;
                end
            end
            CBI_DONE:
            begin
                next_r.busy = 1'b0;
                next_r.bus_oe_n = 1'b1;
                next_r.st = CBI_IDLE;
            end
            CBI_GRANT:
            begin
                if (mastership_request_n)
                begin
                    next_r.grant_n = 1'b1;
                    next_r.st = CBI_IDLE;
                end
            end
            CBI_HALT:
            begin
                if (halt_n)
                    next_r.st = CBI_IDLE;
            end
            default:
                next_r.st = CBI_IDLE;
        endcase
    end

    // ========================================
    // state register, async low reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r <= '0;
            r.as_n <= 1'b1;
            r.uds_n <= 1'b1;
            r.lds_n <= 1'b1;
            r.data_oe_n <= 1'b1;
            r.bus_oe_n <= 1'b1;
            r.grant_n <= 1'b1;
        end
        else
            r <= next_r;
    end

    // ========================================
    // outputs straight from state
    assign core_ready = !r.busy && r.st == CBI_IDLE;
    assign core_rsp = r.rsp;
    assign irq_pending = r.ipl;
    assign mastership_grant_n = r.grant_n;
    assign addr_out = r.cur.addr;
    assign addr_oe_n = r.bus_oe_n;
    assign data_out = r.cur.wdata;
    assign data_oe_n = r.data_oe_n;
    assign addr_strobe_n = r.as_n;
    assign upper_byte_strobe_n = r.uds_n;
    assign lower_byte_strobe_n = r.lds_n;
    assign read_write = r.cur.read;
    assign {space_code_bit2, space_code_bit1, space_code_bit0} = r.cur.fc;

    // ========================================
    // checks
    a_strobe_addr_valid: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !addr_strobe_n |-> !addr_oe_n)
        else $error("strobe without driven address");
    a_fc_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !addr_strobe_n && !$past(addr_strobe_n) |-> $stable(r.cur.fc))
        else $error("function code moved under strobe");
    a_hold_until_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !addr_strobe_n && xfer_ack_n && bus_fault_n && r.wait_cnt != 8'hff
        |=> !addr_strobe_n)
        else $error("strobe dropped early");
    a_ack_ends: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.st == CBI_STRB && !xfer_ack_n |=> addr_strobe_n && core_rsp.done)
        else $error("ack did not end cycle");
    a_fault_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.st == CBI_STRB && !bus_fault_n |=> core_rsp.fault)
        else $error("fault not reported");
    a_grant_no_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !mastership_grant_n |-> addr_strobe_n && addr_oe_n)
        else $error("grant while driving");
    a_nmi_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
        lvl == 3'h7 |=> irq_pending == 3'h7)
        else $error("level seven masked");
    a_iack_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !addr_strobe_n && r.cur.iack |-> addr_out[23:4] == 20'hfffff && addr_out[0])
        else $error("iack address wrong");
    a_halt_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        r.st == CBI_HALT |-> addr_strobe_n)
        else $error("strobe while halted");
    c_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
        r.st == CBI_STRB && r.cur.read && !xfer_ack_n);
    c_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
        r.st == CBI_STRB && !r.cur.read && !xfer_ack_n);
    c_fault: cover property (@(posedge clk_sys) disable iff (!rst_b)
        r.st == CBI_STRB && !bus_fault_n);
    c_grant: cover property (@(posedge clk_sys) disable iff (!rst_b) !mastership_grant_n);
endmodule

//--- cbi_pkg.sv
// types for the cpu bus interface
package cbi_pkg;
    typedef enum logic [2:0]
    {
        CBI_IDLE = 3'b000,
        CBI_ADDR = 3'b001,
        CBI_STRB = 3'b010,
        CBI_DONE = 3'b011,
        CBI_GRANT = 3'b100,
        CBI_HALT = 3'b101
    } cbi_state_t;

    // request from the core side
    typedef struct packed
    {
        logic valid;
        logic read;
        logic iack;
        logic [1:0] size_sel;
        logic [2:0] fc;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cbi_req_t;

    // answer to the core side
    typedef struct packed
    {
        logic done;
        logic fault;
        logic autovec;
        logic [15:0] rdata;
    } cbi_rsp_t;

    typedef struct packed
    {
        cbi_state_t st;
        cbi_req_t cur;
        cbi_rsp_t rsp;
        logic as_n;
        logic uds_n;
        logic lds_n;
        logic data_oe_n;
        logic bus_oe_n;
        logic grant_n;
        logic busy;
        logic [2:0] ipl;
        logic [7:0] wait_cnt;
    } cbi_regs_t;
endpackage

//--- cbi_regs.svh
// timing and field constants for the cpu bus interface
`ifndef CBI_REGS_SVH
`define CBI_REGS_SVH
`define CBI_ADDR_W 24
`define CBI_DATA_W 16
`define CBI_FC_IACK 3'h7
`define CBI_ACK_TIMEOUT 8'hff
`endif

//--- cbi_slave_model.sv
// behavioural slave on the far side of the bus interface
`timescale 1ns/1ps
module cbi_slave_model
(
    input wire logic clk_sys,
    input wire logic addr_strobe_n,
    input wire logic read_write,
    input wire logic [23:0] addr_out,
    input wire logic hold_ack,
    input wire logic [3:0] ack_wait,
    output logic xfer_ack_n,
    output logic [15:0] data_in
);
    logic [3:0] cnt;
    initial
    begin
        xfer_ack_n = 1'b1;
        data_in = 16'h0000;
        cnt = 4'h0;
    end
    // ack after wait
    // a released data bus toggles so that no stale value can pass for a read
    always @(negedge clk_sys)
    begin
        if (addr_strobe_n)
        begin
            xfer_ack_n <= 1'b1;
            cnt <= 4'h0;
            data_in <= ~data_in;
        end
        else if (cnt >= ack_wait && !hold_ack)
        begin
            xfer_ack_n <= 1'b0;
            data_in <= read_write ? (addr_out[15:0] ^ 16'h5a5a) : ~data_in;
        end
        else
        begin
            cnt <= cnt + 4'h1;
            data_in <= ~data_in;
        end
    end
endmodule

//--- cpu_async_bus_interface_tb.sv
// self-checking bench for the cpu bus interface
`timescale 1ns/1ps
module cpu_async_bus_interface_tb;
    import cbi_pkg::*;
    logic clk_sys = 1'b0, rst_b = 1'b0, hold_ack = 1'b0, fault_n = 1'b1, auto_vector_req_n_n = 1'b1;
    logic req_n = 1'b1, core_ready, grant_n, ack_n, addr_strobe_n, ub_n, lb_n, rw, aoe_n;
    logic [3:0] ack_wait = 4'h0;
    logic [2:0] irq_mask = 3'h0, irq_n = 3'h7, irq_pending, fc, s_fc;
    logic [23:0] addr_out, s_addr;
    logic [15:0] data_out, data_in, s_dat;
    logic [1:0] s_lanes;
    logic s_rw, s_aoe, s_doe, doe_n, width_16 = 1'b1, halt_n = 1'b1;
    cbi_req_t core_req = '0;
    cbi_rsp_t core_rsp, rsp;
    int n_fail = 0, comparisons = 0, cyc = 0, n_wait;
    cbi_bus_if u_cbi_bus_if (.clk_sys(clk_sys), .rst_b(rst_b), .core_req(core_req),
        .core_ready(core_ready), .core_rsp(core_rsp), .irq_mask(irq_mask),
        .irq_pending(irq_pending), .width_sel_16(width_16), .halt_n(halt_n), .xfer_ack_n(ack_n),
        .bus_fault_n(fault_n), .auto_vector_req_n(auto_vector_req_n_n), .mastership_request_n(req_n),
        .mastership_grant_n(grant_n), .irq_level_bit2_n(irq_n[2]),
        .irq_level_bit1_n(irq_n[1]), .irq_level_bit0_n(irq_n[0]), .addr_out(addr_out),
        .addr_oe_n(aoe_n), .data_out(data_out), .data_in(data_in), .data_oe_n(doe_n),
        .addr_strobe_n(addr_strobe_n), .upper_byte_strobe_n(ub_n), .lower_byte_strobe_n(lb_n),
        .read_write(rw), .space_code_bit2(fc[2]), .space_code_bit1(fc[1]),
        .space_code_bit0(fc[0]));
    cbi_slave_model u_cbi_slave_model (.clk_sys(clk_sys), .addr_strobe_n(addr_strobe_n),
        .read_write(rw), .addr_out(addr_out), .hold_ack(hold_ack), .ack_wait(ack_wait),
        .xfer_ack_n(ack_n), .data_in(data_in));
    // ==========================================
    // clock, watchdog and bus snapshot
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    // the snapshot keeps the last strobed values for checks after the cycle
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
        if (addr_strobe_n === 1'b0)
        begin
            s_addr <= addr_out;
            s_fc <= fc;
            s_rw <= rw;
            s_dat <= data_out;
            s_lanes <= {ub_n, lb_n};
            s_aoe <= aoe_n;
            s_doe <= doe_n;
        end
    end
    // ==========================================
    // shared tasks
    task chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer: request held for one clock, then wait bounded for done
    task xfer(input logic rd, input logic ia, input logic [1:0] sz, input logic [2:0] f,
        input logic [23:0] ad, input logic [15:0] wd);
        core_req = '{1'b1, rd, ia, sz, f, ad, wd};
        @(negedge clk_sys);
        core_req.valid = 1'b0;
        for (n_wait = 0; n_wait < 300 && core_rsp.done !== 1'b1; n_wait++) @(negedge clk_sys);
        rsp = core_rsp;
        chk("done", rsp.done, 1'b1);
        repeat (2) @(negedge clk_sys);
    endtask
    task finish_test();
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task t_fault();
        fault_n = 1'b0;
        xfer(1'b1, 1'b0, 2'b00, 3'h1, 24'h000100, 16'h0000);
        fault_n = 1'b1;
        chk("fault", rsp.fault, 1'b1);
        chk("fast end", n_wait < 20, 1'b1);
    endtask
    task t_timeout();
        hold_ack = 1'b1;
        xfer(1'b1, 1'b0, 2'b00, 3'h2, 24'h000200, 16'h0000);
        hold_ack = 1'b0;
        chk("timeout fault", rsp.fault, 1'b1);
        chk("timeout wait", n_wait >= 250, 1'b1);
    endtask
    // reset in mid-cycle must drop strobes and free the bus at once
    task t_reset();
        hold_ack = 1'b1;
        core_req = '{1'b1, 1'b1, 1'b0, 2'b00, 3'h1, 24'h000300, 16'h0000};
        repeat (4) @(negedge clk_sys);
        core_req.valid = 1'b0;
        chk("strobe before reset", addr_strobe_n, 1'b0);
        rst_b = 1'b0;
        @(negedge clk_sys);
        chk("reset strobe", addr_strobe_n, 1'b1);
        chk("reset bus", aoe_n, 1'b1);
        chk("reset ready", core_ready, 1'b1);
        rst_b = 1'b1;
        hold_ack = 1'b0;
        @(negedge clk_sys);
    endtask
    task t_read();
        xfer(1'b1, 1'b0, 2'b00, 3'h5, 24'h123456, 16'h0000);
        chk("rdata", rsp.rdata, 16'h3456 ^ 16'h5a5a);
        chk("fault clear", rsp.fault, 1'b0);
        chk("rw read", s_rw, 1'b1);
        chk("fc", s_fc, 3'h5);
        chk("addr", s_addr, 24'h123456);
        chk("addr driven", s_aoe, 1'b0);
        chk("data bus off", s_doe, 1'b1);
        chk("no autovec", rsp.autovec, 1'b0);
        chk("bus released", aoe_n, 1'b1);
    endtask
    // a request offered while halted must not start a cycle; a fresh one runs once the halt lifts
    task t_halt();
        halt_n = 1'b0;
        @(negedge clk_sys);
        chk("halt not ready", core_ready, 1'b0);
        core_req = '{1'b1, 1'b1, 1'b0, 2'b00, 3'h1, 24'h000400, 16'h0000};
        repeat (3) @(negedge clk_sys);
        chk("halt no strobe", addr_strobe_n, 1'b1);
        chk("halt bus off", aoe_n, 1'b1);
        core_req.valid = 1'b0;
        halt_n = 1'b1;
        @(negedge clk_sys);
        xfer(1'b1, 1'b0, 2'b00, 3'h1, 24'h000400, 16'h0000);
        chk("after halt", rsp.fault, 1'b0);
    endtask
    // slow slave, each lane choice in turn, then one byte-wide write
    task t_write();
        ack_wait = 4'h9;
        for (int sz = 0; sz < 3; sz++)
        begin
            xfer(1'b0, 1'b0, sz[1:0], 3'h1, 24'h000a0a, 16'hbeef);
            chk("lanes", s_lanes, sz[1:0]);
            chk("wdata", s_dat, 16'hbeef);
            chk("rw write", s_rw, 1'b0);
            chk("data driven", s_doe, 1'b0);
        end
        width_16 = 1'b0;
        xfer(1'b0, 1'b0, 2'b00, 3'h1, 24'h000a0b, 16'h00ef);
        width_16 = 1'b1;
        chk("byte lanes", s_lanes, 2'b10);
        ack_wait = 4'h0;
    endtask
    // the core asks for another space; iack must still show its own code
    task t_iack();
        auto_vector_req_n_n = 1'b0;
        xfer(1'b1, 1'b1, 2'b00, 3'h2, 24'h00000a, 16'h0000);
        auto_vector_req_n_n = 1'b1;
        chk("iack addr", s_addr, 24'hfffffb);
        chk("iack fc", s_fc, 3'h7);
        chk("autovec", rsp.autovec, 1'b1);
    endtask
    task t_grant();
        req_n = 1'b0;
        for (int i = 0; i < 10 && grant_n !== 1'b0; i++) @(negedge clk_sys);
        chk("grant", grant_n, 1'b0);
        chk("grant bus off", aoe_n, 1'b1);
        req_n = 1'b1;
        for (int i = 0; i < 10 && grant_n !== 1'b1; i++) @(negedge clk_sys);
        chk("grant off", grant_n, 1'b1);
    endtask
    // level, mask and expected pending level packed per entry
    task t_irq();
        automatic logic [8:0] tbl [3] = '{9'o777, 9'o350, 9'o626};
        for (int i = 0; i < 3; i++)
        begin
            irq_n = ~tbl[i][8:6];
            irq_mask = tbl[i][5:3];
            repeat (3) @(negedge clk_sys);
            chk("pending", irq_pending, tbl[i][2:0]);
        end
    endtask
    initial
    begin
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        t_fault();
        t_timeout();
        t_reset();
        t_read();
        t_halt();
        t_write();
        t_iack();
        t_grant();
        t_irq();
        finish_test();
    end
endmodule
